// >>> design/cdma_top.sv
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - at the end of a buffer a channel reloads index, modify and count from the block its chain pointer names and carries on alone.
// - the chain pointer holds the address of the next block's index word (word seven), and a block that points at itself repeats one buffer forever.
// - a channel chains only while both its port enable and its chaining enable bit are set.
// - block word seven holds the buffer start address, loaded as the index.
// - block word six holds the modify step added after every word.
// - block word five holds the word count for the buffer.
// - block word four holds the next pointer: a 17-bit address under mask 0x0001ffff; bit 17 is stored and read back but never gates the interrupt.
// - writing the chain pointer starts the chain at once if both its port enable and chaining enable bits are set, else the start waits for both.
// - a channel raises its interrupt request each time its count steps down to zero.
// - transmit and receive channels chain independently, each with its own pointer, block and count.
// - a full receive buffer raises the receive interrupt, reloads and refills the same buffer.
// - a fully sent transmit buffer reloads and is sent again from the same memory.
// - buffer words map one to one onto audio slots, left first then right, alternating.
// - a block is eight words; a stereo pair uses count 2 and modify 1.
module cdma_top
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // interrupt
  output logic irq,
  // serial receive, a then b
  input wire logic [1:0] rx_word_valid,
  input wire logic [1:0][31:0] rx_word,
  // serial transmit, a then b
  input wire logic [1:0] tx_word_req,
  output logic [1:0] tx_word_valid,
  output logic [1:0][31:0] tx_word,
  // internal memory
  output logic mem_req,
  output logic mem_we,
  output logic [16:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_rvalid
);
  // ****************************************
  // decoding helpers
  // ****************************************
  // channels 0,1 receive a,b; channels 2,3 transmit a,b
  function automatic logic ch_enabled(input logic [3:0] tc,
    input logic [3:0] rc, input int ch);
    logic [3:0] c;
    c = (ch >= 2) ? tc : rc;
    if (ch % 2 == 1)
      return c[cdma_pkg::CTL_EN_B] & c[cdma_pkg::CTL_CHEN_B];
    return c[cdma_pkg::CTL_EN_A] & c[cdma_pkg::CTL_CHEN_A];
  endfunction

  // registers of one channel sit on an eight-word stride
  function automatic logic ch_hit(input logic [7:0] a, input int ch,
    input logic [7:0] ofs);
    return a == 8'(ch * 8) + ofs;
  endfunction

  // block word k sits k below the index word the pointer names
  function automatic logic [16:0] tcb_addr(input logic [17:0] cp,
    input logic [1:0] k);
    logic [17:0] a;
    a = cp & cdma_pkg::CP_ADDR_MASK;
    return a[16:0] - {15'h0000, k};
  endfunction

  // ****************************************
  // shared state
  // ****************************************
  cdma_mem_if mif();
  logic [3:0] tx_ctl_r, tx_ctl_nxt, rx_ctl_r, rx_ctl_nxt;
  logic [7:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic irq_r, irq_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [16:0] ch_idx [4];
  logic [16:0] ch_mod [4];
  logic [15:0] ch_cnt [4];
  logic [17:0] ch_cp [4];
  logic [3:0] ch_done, ch_ovr;

  // ****************************************
  // channel engines
  // ****************************************
  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_ch
      localparam bit IS_TX = (g >= 2);
      cdma_pkg::cdma_state_type st_r, st_nxt;
      logic [16:0] idx_r, idx_nxt, mod_r, mod_nxt;
      logic [15:0] cnt_r, cnt_nxt;
      logic [17:0] cp_r, cp_nxt;
      logic [1:0] fw_r, fw_nxt;
      logic arm_r, arm_nxt, wait_r, wait_nxt;
      logic done_r, done_nxt, txv_r, txv_nxt;
      logic [31:0] txd_r, txd_nxt;
      logic en, cp_wr, take, full, put, finish;
      logic [31:0] hold, put_data;

      assign en = ch_enabled(tx_ctl_r, rx_ctl_r, g);
      assign cp_wr = reg_wr && ch_hit(reg_addr, g, cdma_pkg::REG_CP_OFS);
      if (IS_TX)
      begin : g_tx
        assign put = tx_word_req[g - 2];
        assign put_data = cdma_pkg::WORD_RST;
      end
      else
      begin : g_rx
        assign put = rx_word_valid[g];
        assign put_data = rx_word[g];
      end

      // one word of slack so a slot arriving mid-fetch is not lost
      cdma_stage u_stage
      (
        .mclk(mclk),
        .reset_n(reset_n),
        .put(put),
        .put_data(put_data),
        .take(take),
        .full(full),
        .data(hold),
        .overrun(ch_ovr[g])
      );

      always_comb
      begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        mod_nxt = mod_r;
        cnt_nxt = cnt_r;
        cp_nxt = cp_r;
        fw_nxt = fw_r;
        arm_nxt = arm_r;
        wait_nxt = wait_r;
        done_nxt = 1'b0;
        txv_nxt = 1'b0;
        txd_nxt = txd_r;
        take = 1'b0;
        finish = 1'b0;
        if (cp_wr)
        begin
          cp_nxt = reg_wdata[17:0];
          arm_nxt = 1'b1;
          wait_nxt = 1'b0;
          st_nxt = cdma_pkg::CDMA_IDLE;
        end
        else
        begin
          unique case (st_r)
            cdma_pkg::CDMA_IDLE:
            begin
              if (arm_r && en)
              begin
                arm_nxt = 1'b0;
                fw_nxt = 2'h0;
                st_nxt = cdma_pkg::CDMA_FETCH;
              end
            end
            cdma_pkg::CDMA_FETCH:
            begin
              if (wait_r && mif.rvalid[g])
              begin
                wait_nxt = 1'b0;
                unique case (fw_r)
                  2'h0: idx_nxt = mif.rdata[16:0];
                  2'h1: mod_nxt = mif.rdata[16:0];
                  2'h2: cnt_nxt = mif.rdata[15:0];
                  2'h3: cp_nxt = mif.rdata[17:0];
                endcase
                fw_nxt = fw_r + 2'h1;
                if (fw_r == cdma_pkg::TCB_LAST)
                  st_nxt = cdma_pkg::CDMA_RUN;
              end
              else if (mif.gnt[g])
                wait_nxt = 1'b1;
            end
            cdma_pkg::CDMA_RUN:
            begin
              // a zero count ends the buffer before any word moves
              if (cnt_r == cdma_pkg::CNT_RST)
              begin
                fw_nxt = 2'h0;
                st_nxt = cdma_pkg::CDMA_FETCH;
              end
              else if (full && en)
                st_nxt = cdma_pkg::CDMA_XFER;
            end
            cdma_pkg::CDMA_XFER:
            begin
              if (IS_TX && wait_r && mif.rvalid[g])
              begin
                wait_nxt = 1'b0;
                txd_nxt = mif.rdata;
                txv_nxt = 1'b1;
                finish = 1'b1;
              end
              else if (mif.gnt[g] && !IS_TX)
                finish = 1'b1;
              else if (mif.gnt[g])
                wait_nxt = 1'b1;
            end
          endcase
          if (finish)
          begin
            take = 1'b1;
            idx_nxt = idx_r + mod_r;
            cnt_nxt = cnt_r - 16'h0001;
            if (cnt_r == 16'h0001)
            begin
              done_nxt = 1'b1;
              fw_nxt = 2'h0;
              st_nxt = cdma_pkg::CDMA_FETCH;
            end
            else
              st_nxt = cdma_pkg::CDMA_RUN;
          end
        end
      end

      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          st_r <= cdma_pkg::CDMA_IDLE;
          idx_r <= cdma_pkg::ADDR_RST;
          mod_r <= cdma_pkg::ADDR_RST;
          cnt_r <= cdma_pkg::CNT_RST;
          cp_r <= cdma_pkg::CP_RST;
          fw_r <= 2'h0;
          arm_r <= 1'b0;
          wait_r <= 1'b0;
          done_r <= 1'b0;
          txv_r <= 1'b0;
          txd_r <= cdma_pkg::WORD_RST;
        end
        else
        begin
          st_r <= st_nxt;
          idx_r <= idx_nxt;
          mod_r <= mod_nxt;
          cnt_r <= cnt_nxt;
          cp_r <= cp_nxt;
          fw_r <= fw_nxt;
          arm_r <= arm_nxt;
          wait_r <= wait_nxt;
          done_r <= done_nxt;
          txv_r <= txv_nxt;
          txd_r <= txd_nxt;
        end
      end

      // each channel keeps its own pointer, block and count
      assign mif.req[g] = (st_r == cdma_pkg::CDMA_FETCH ||
        st_r == cdma_pkg::CDMA_XFER) && !wait_r;
      assign mif.we[g] = !IS_TX && st_r == cdma_pkg::CDMA_XFER;
      assign mif.addr[g] = (st_r == cdma_pkg::CDMA_FETCH) ?
        tcb_addr(cp_r, fw_r) : idx_r;
      assign mif.wdata[g] = hold;
      assign ch_idx[g] = idx_r;
      assign ch_mod[g] = mod_r;
      assign ch_cnt[g] = cnt_r;
      assign ch_cp[g] = cp_r;
      assign ch_done[g] = done_r;
      if (IS_TX)
      begin : g_txo
        assign tx_word[g - 2] = txd_r;
        assign tx_word_valid[g - 2] = txv_r;
      end
    end
  endgenerate

  // ****************************************
  // memory port
  // ****************************************
  cdma_arb u_arb
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .m(mif.arb),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid)
  );

  // ****************************************
  // register port and interrupt
  // ****************************************
  always_comb
  begin
    tx_ctl_nxt = tx_ctl_r;
    rx_ctl_nxt = rx_ctl_r;
    mask_nxt = mask_r;
    rdata_nxt = cdma_pkg::WORD_RST;
    stat_nxt = stat_r;
    if (reg_wr && reg_addr == cdma_pkg::REG_TX_CTL)
      tx_ctl_nxt = reg_wdata[3:0];
    if (reg_wr && reg_addr == cdma_pkg::REG_RX_CTL)
      rx_ctl_nxt = reg_wdata[3:0];
    if (reg_wr && reg_addr == cdma_pkg::REG_IRQ_MASK)
      mask_nxt = reg_wdata[7:0];
    if (reg_rd)
    begin
      for (int c = 0; c < 4; c++)
      begin
        if (ch_hit(reg_addr, c, cdma_pkg::REG_IDX_OFS))
          rdata_nxt = {15'h0000, ch_idx[c]};
        if (ch_hit(reg_addr, c, cdma_pkg::REG_MOD_OFS))
          rdata_nxt = {15'h0000, ch_mod[c]};
        if (ch_hit(reg_addr, c, cdma_pkg::REG_CNT_OFS))
          rdata_nxt = {16'h0000, ch_cnt[c]};
        if (ch_hit(reg_addr, c, cdma_pkg::REG_CP_OFS))
          rdata_nxt = {14'h0000, ch_cp[c]};
      end
      if (reg_addr == cdma_pkg::REG_TX_CTL)
        rdata_nxt = {28'h0000000, tx_ctl_r};
      if (reg_addr == cdma_pkg::REG_RX_CTL)
        rdata_nxt = {28'h0000000, rx_ctl_r};
      if (reg_addr == cdma_pkg::REG_IRQ_MASK)
        rdata_nxt = {24'h000000, mask_r};
      if (reg_addr == cdma_pkg::REG_IRQ_STAT)
      begin
        rdata_nxt = {24'h000000, stat_r};
        stat_nxt = cdma_pkg::STAT_RST;
      end
    end
    // a new event in the clearing cycle stays set
    stat_nxt = stat_nxt | {ch_ovr, ch_done};
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_ctl_r <= cdma_pkg::CTL_RST;
      rx_ctl_r <= cdma_pkg::CTL_RST;
      stat_r <= cdma_pkg::STAT_RST;
      mask_r <= cdma_pkg::STAT_RST;
      irq_r <= 1'b0;
      rdata_r <= cdma_pkg::WORD_RST;
    end
    else
    begin
      tx_ctl_r <= tx_ctl_nxt;
      rx_ctl_r <= rx_ctl_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq = irq_r;
endmodule
`default_nettype wire

// >>> design/cdma_pkg.sv
package cdma_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int NCH = 4;
  localparam int AW = 17;
  localparam int DW = 32;
  localparam int CW = 16;
  localparam int PW = 18;
  // ****************************************
  // register offsets on the plain port
  // ****************************************
  localparam logic [7:0] REG_IDX_OFS = 8'h00;
  localparam logic [7:0] REG_MOD_OFS = 8'h01;
  localparam logic [7:0] REG_CNT_OFS = 8'h02;
  localparam logic [7:0] REG_CP_OFS = 8'h03;
  localparam logic [7:0] REG_TX_CTL = 8'h20;
  localparam logic [7:0] REG_RX_CTL = 8'h21;
  localparam logic [7:0] REG_IRQ_STAT = 8'h22;
  localparam logic [7:0] REG_IRQ_MASK = 8'h23;
  // ****************************************
  // control bits and chain pointer layout
  // ****************************************
  localparam int CTL_EN_A = 0;
  localparam int CTL_CHEN_A = 1;
  localparam int CTL_EN_B = 2;
  localparam int CTL_CHEN_B = 3;
  localparam logic [PW-1:0] CP_ADDR_MASK = 18'h1ffff;
  localparam int CP_PCI_BIT = 17;
  // ****************************************
  // transfer control block, word offsets
  // ****************************************
  localparam int TCB_WORDS = 8;
  localparam logic [2:0] TCB_IDX_OFS = 3'h7;
  localparam logic [2:0] TCB_MOD_OFS = 3'h6;
  localparam logic [2:0] TCB_CNT_OFS = 3'h5;
  localparam logic [2:0] TCB_CP_OFS = 3'h4;
  localparam logic [1:0] TCB_LAST = 2'h3;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [AW-1:0] ADDR_RST = 17'h00000;
  localparam logic [CW-1:0] CNT_RST = 16'h0000;
  localparam logic [PW-1:0] CP_RST = 18'h00000;
  localparam logic [3:0] CTL_RST = 4'h0;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [DW-1:0] WORD_RST = 32'h00000000;
  typedef enum logic [3:0] {
    CDMA_IDLE = 4'b0001,
    CDMA_FETCH = 4'b0010,
    CDMA_RUN = 4'b0100,
    CDMA_XFER = 4'b1000
  } cdma_state_type;
endpackage

// >>> design/cdma_mem_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cdma_mem_if;
  logic req [4];
  logic we [4];
  logic [16:0] addr [4];
  logic [31:0] wdata [4];
  logic gnt [4];
  logic rvalid [4];
  logic [31:0] rdata;
  modport chan (output req, output we, output addr, output wdata,
    input gnt, input rvalid, input rdata);
  modport arb (input req, input we, input addr, input wdata,
    output gnt, output rvalid, output rdata);
endinterface
`default_nettype wire

// >>> design/cdma_stage.sv
`timescale 1ns/1ns
`default_nettype none
module cdma_stage
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // serial side
  input wire logic put,
  input wire logic [31:0] put_data,
  // channel side
  input wire logic take,
  output logic full,
  output logic [31:0] data,
  output logic overrun
);
  logic full_r, full_nxt;
  logic ovr_r, ovr_nxt;
  logic [31:0] data_r, data_nxt;

  // new arrival beats the consume in the same cycle
  always_comb
  begin
    full_nxt = put | (full_r & ~take);
    data_nxt = put ? put_data : data_r;
    ovr_nxt = put & full_r & ~take;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      full_r <= 1'b0;
      ovr_r <= 1'b0;
      data_r <= cdma_pkg::WORD_RST;
    end
    else
    begin
      full_r <= full_nxt;
      ovr_r <= ovr_nxt;
      data_r <= data_nxt;
    end
  end

  assign full = full_r;
  assign data = data_r;
  assign overrun = ovr_r;
endmodule
`default_nettype wire

// >>> design/cdma_arb.sv
`timescale 1ns/1ns
`default_nettype none
module cdma_arb
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // channel side
  cdma_mem_if.arb m,
  // memory side
  output logic mem_req,
  output logic mem_we,
  output logic [16:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_rvalid
);
  logic req_r, req_nxt, we_r, we_nxt, busy_r, busy_nxt, found;
  logic [1:0] last_r, last_nxt, own_r, own_nxt, sel, j;
  logic [16:0] addr_r, addr_nxt;
  logic [31:0] wd_r, wd_nxt;

  // round robin so a busy receive channel cannot starve a transmit one
  always_comb
  begin
    found = 1'b0;
    sel = 2'h0;
    j = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      j = 2'(last_r + 2'(i) + 2'h1);
      if (!busy_r && !found && m.req[j])
      begin
        found = 1'b1;
        sel = j;
      end
    end
    for (int i = 0; i < 4; i++)
    begin
      m.gnt[i] = found && (sel == 2'(i));
      m.rvalid[i] = mem_rvalid && busy_r && (own_r == 2'(i));
    end
    m.rdata = mem_rdata;
    req_nxt = found;
    we_nxt = found & m.we[sel];
    addr_nxt = found ? m.addr[sel] : addr_r;
    wd_nxt = found ? m.wdata[sel] : wd_r;
    busy_nxt = busy_r ? ~mem_rvalid : (found & ~m.we[sel]);
    own_nxt = found ? sel : own_r;
    last_nxt = found ? sel : last_r;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_r <= 1'b0;
      we_r <= 1'b0;
      busy_r <= 1'b0;
      own_r <= 2'h0;
      last_r <= 2'h3;
      addr_r <= cdma_pkg::ADDR_RST;
      wd_r <= cdma_pkg::WORD_RST;
    end
    else
    begin
      req_r <= req_nxt;
      we_r <= we_nxt;
      busy_r <= busy_nxt;
      own_r <= own_nxt;
      last_r <= last_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
    end
  end

  assign mem_req = req_r;
  assign mem_we = we_r;
  assign mem_addr = addr_r;
  assign mem_wdata = wd_r;
endmodule
`default_nettype wire

// >>> test/cdma_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// internal memory holding buffers and blocks
// ****************************************
module cdma_mem_model
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // latency select, high gives a slow memory
  input wire logic slow,
  // memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [16:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_rvalid
);
  logic [31:0] mem [0:1023];
  logic [9:0] addr_r;
  logic [1:0] wait_r;
  logic busy_r;
  // read data toggles when idle so stale data never looks valid
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_rvalid <= 1'b0;
      mem_rdata <= 32'h5a5a5a5a;
      busy_r <= 1'b0;
      wait_r <= 2'h0;
      addr_r <= 10'h000;
    end
    else
    begin
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && mem_we)
        mem[mem_addr[9:0]] <= mem_wdata;
      if (mem_req && !mem_we)
      begin
        busy_r <= 1'b1;
        wait_r <= slow ? 2'h3 : 2'h0;
        addr_r <= mem_addr[9:0];
      end
      else if (busy_r && wait_r == 2'h0)
      begin
        mem_rvalid <= 1'b1;
        mem_rdata <= mem[addr_r];
        busy_r <= 1'b0;
      end
      else if (busy_r)
        wait_r <= wait_r - 2'h1;
    end
  end
endmodule
`default_nettype wire

// >>> test/cdma_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module cdma_top_sva
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq,
  // serial transmit
  input wire logic [1:0] tx_word_valid,
  input wire logic [1:0][31:0] tx_word,
  // memory
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [16:0] mem_addr,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_rvalid
);
  // ****************************************
  // shadow state
  // ****************************************
  logic [7:0] mask_r, mask_nxt;
  logic [3:0] rxc_r, rxc_nxt;
  logic [16:0] cp_r, cp_nxt;
  logic out_r, out_nxt;
  always_comb
  begin
    mask_nxt = (reg_wr && reg_addr == 8'h23) ? reg_wdata[7:0] : mask_r;
    rxc_nxt = (reg_wr && reg_addr == 8'h21) ? reg_wdata[3:0] : rxc_r;
    cp_nxt = (reg_wr && reg_addr == 8'h03) ? reg_wdata[16:0] : cp_r;
    out_nxt = (mem_req && !mem_we) ? 1'b1 : (mem_rvalid ? 1'b0 : out_r);
  end
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mask_r <= 8'h00;
      rxc_r <= 4'h0;
      cp_r <= 17'h00000;
      out_r <= 1'b0;
    end
    else
    begin
      mask_r <= mask_nxt;
      rxc_r <= rxc_nxt;
      cp_r <= cp_nxt;
      out_r <= out_nxt;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'hff |=>
    reg_rdata == 32'h0) else $error("unmapped read not zero");
  AST_MASK_READ: assert property (reg_rd && reg_addr == 8'h23 |=>
    reg_rdata == {24'h0, mask_r}) else $error("mask read wrong");
  AST_IRQ_OFF: assert property (mask_r == 8'h00 &&
    $past(mask_r) == 8'h00 |-> !irq) else $error("irq high while all masked");
  AST_ONE_READ: assert property (out_r |-> !mem_req)
    else $error("request while read outstanding");
  AST_TX_DATA: assert property (tx_word_valid[0] |->
    $past(mem_rvalid) && tx_word[0] == $past(mem_rdata))
    else $error("tx word not memory data");
  AST_TX_PULSE: assert property (tx_word_valid[0] |=>
    !tx_word_valid[0]) else $error("tx valid longer than one cycle");
  AST_TX_HOLD: assert property (!tx_word_valid[0] |->
    $stable(tx_word[0])) else $error("tx word changed without valid");
  AST_CHAIN_START: assert property (reg_wr && reg_addr == 8'h03 &&
    rxc_r[1:0] == 2'b11 |-> ##[1:8] mem_req && !mem_we && mem_addr == cp_r)
    else $error("chain fetch did not start at pointer");
  cover property (irq);
  cover property (tx_word_valid[0]);
  cover property (mem_req && mem_we);
endmodule
`default_nettype wire

// >>> test/cdma_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cdma_top_tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] rx_word_valid = 2'b00;
  logic [1:0][31:0] rx_word = '0;
  logic [1:0] tx_word_req = 2'b00;
  logic slow = 1'b0;
  logic [31:0] reg_rdata, mem_wdata, mem_rdata;
  logic [1:0] tx_word_valid;
  logic [1:0][31:0] tx_word;
  logic irq, mem_req, mem_we, mem_rvalid;
  logic [16:0] mem_addr;
  int failures = 0;
  int n_compared = 0;
  int n_rv = 0;
  int n_wr = 0;
  always #5 mclk = ~mclk;
  cdma_top cdma_top_i (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .rx_word_valid(rx_word_valid),
    .rx_word(rx_word), .tx_word_req(tx_word_req),
    .tx_word_valid(tx_word_valid), .tx_word(tx_word), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
  cdma_mem_model cdma_mem_model_i (.mclk(mclk), .reset_n(reset_n),
    .slow(slow), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
  always @(posedge mclk)
  begin
    if (reset_n && mem_rvalid)
      n_rv++;
    if (reset_n && mem_req && mem_we)
      n_wr++;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic report_and_stop;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic give_up;
    failures++;
    $display("MISMATCH t=%0t wait ran out", $time);
    report_and_stop();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk32(d, exp);
  endtask
  // waits for memory answers and writes, bounded
  task automatic wait_mem(input int nr, input int nw);
    int i;
    for (i = 0; i < 300 && (n_rv < nr || n_wr < nw); i++)
      @(negedge mclk);
    if (n_rv < nr || n_wr < nw)
      give_up();
    @(posedge mclk);
  endtask
  task automatic rx_put(input int k, input logic [31:0] d);
    int w;
    w = n_wr;
    @(posedge mclk);
    rx_word_valid[k] <= 1'b1;
    rx_word[k] <= d;
    @(posedge mclk);
    rx_word_valid[k] <= 1'b0;
    rx_word[k] <= ~d;
    wait_mem(n_rv, w + 1);
  endtask
  task automatic tx_get(input int k, input logic [31:0] exp);
    int i;
    @(posedge mclk);
    tx_word_req[k] <= 1'b1;
    @(posedge mclk);
    tx_word_req[k] <= 1'b0;
    for (i = 0; i < 100 && tx_word_valid[k] !== 1'b1; i++)
      @(negedge mclk);
    if (i == 100)
      give_up();
    chk32(tx_word[k], exp);
  endtask
  // software side fills a self-pointing block, stereo pair
  task automatic tcb(input int b, input logic [31:0] buf_a);
    cdma_mem_model_i.mem[b + 7] = buf_a;
    cdma_mem_model_i.mem[b + 6] = 32'h1;
    cdma_mem_model_i.mem[b + 5] = 32'h2;
    cdma_mem_model_i.mem[b + 4] = 32'h00020000 | (b + 7);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [31:0] d;
    tcb(32'h40, 32'h100);
    tcb(32'h60, 32'h200);
    cdma_mem_model_i.mem[10'h200] = 32'h11111111;
    cdma_mem_model_i.mem[10'h201] = 32'h22222222;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rd_chk(8'h22, 32'h0);
    rd_chk(8'h02, 32'h0);
    wr(8'hff, 32'hffffffff);
    rd_chk(8'hff, 32'h0);
    wr(8'h23, 32'h0000000f);
    rd_chk(8'h23, 32'h0000000f);
    wr(8'h21, 32'h1);
    wr(8'h03, 32'h00020047);
    repeat (10) @(posedge mclk);
    chk32(32'(n_rv), 32'h0);
    wr(8'h21, 32'h3);
    wait_mem(4, 0);
    rd_chk(8'h00, 32'h100);
    rd_chk(8'h01, 32'h1);
    rd_chk(8'h02, 32'h2);
    rd_chk(8'h03, 32'h00020047);
    rx_put(0, 32'haaaa0001);
    chk1(irq, 1'b0);
    rx_put(0, 32'hbbbb0002);
    wait_mem(8, 2);
    chk1(irq, 1'b1);
    chk32(cdma_mem_model_i.mem[10'h100], 32'haaaa0001);
    chk32(cdma_mem_model_i.mem[10'h101], 32'hbbbb0002);
    rd_chk(8'h22, 32'h1);
    @(negedge mclk);
    chk1(irq, 1'b0);
    rd_chk(8'h00, 32'h100);
    wr(8'h03, 32'h00020047);
    wait_mem(12, 2);
    rx_put(0, 32'hcccc0003);
    rx_put(0, 32'hdddd0004);
    wait_mem(16, 4);
    chk32(cdma_mem_model_i.mem[10'h100], 32'hcccc0003);
    chk32(cdma_mem_model_i.mem[10'h101], 32'hdddd0004);
    rd_chk(8'h22, 32'h1);
    wr(8'h23, 32'h0);
    slow <= 1'b1;
    wr(8'h20, 32'h3);
    wr(8'h13, 32'h00020067);
    wait_mem(20, 4);
    tx_get(0, 32'h11111111);
    tx_get(0, 32'h22222222);
    wait_mem(26, 4);
    tx_get(0, 32'h11111111);
    chk1(irq, 1'b0);
    rd_chk(8'h22, 32'h4);
    rd_chk(8'h02, 32'h2);
    rd_chk(8'h12, 32'h1);
    @(posedge mclk);
    tx_word_req[0] <= 1'b1;
    @(posedge mclk);
    tx_word_req[0] <= 1'b0;
    tx_get(0, 32'h22222222);
    rd(8'h22, d);
    chk32(d & 32'h40, 32'h40);
    report_and_stop();
  end
endmodule
bind cdma_top cdma_top_sva cdma_top_sva_i (.mclk(mclk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .tx_word_valid(tx_word_valid), .tx_word(tx_word), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
  .mem_rvalid(mem_rvalid));
`default_nettype wire
